// ### verilog/stream_aux_rx_pkg.sv
// package: register map, field layout, reset values and decode types of the config bank
package stream_aux_rx_pkg;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] STREAM_MODE_SETUP_IDX = 8'h08;
   localparam logic [7:0] AUX_FRAMING_OPTIONS_IDX = 8'h09;
   localparam logic [7:0] RECEIVER_SETUP_ONE_IDX = 8'h0A;
   localparam logic [7:0] CONTROL_IDX = 8'h0B;
   localparam logic [7:0] STATUS_IDX = 8'h0C;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] STREAM_MODE_SETUP_ADDR = ADDR_W'({STREAM_MODE_SETUP_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] AUX_FRAMING_OPTIONS_ADDR =
      ADDR_W'({AUX_FRAMING_OPTIONS_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] RECEIVER_SETUP_ONE_ADDR = ADDR_W'({RECEIVER_SETUP_ONE_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] CONTROL_ADDR = ADDR_W'({CONTROL_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'({STATUS_IDX, 2'b00});

   // ----------------------------------------------------------------------
   // reset values and write mask
   // ----------------------------------------------------------------------
   localparam logic [7:0] STREAM_MODE_SETUP_RST = 8'h00;
   localparam logic [7:0] AUX_FRAMING_OPTIONS_RST = 8'h04;
   localparam logic [7:0] RECEIVER_SETUP_ONE_RST = 8'h00;
   localparam logic [7:0] STREAM_MODE_WMASK = 8'h7F;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int SCF_LSB = 5;
   localparam int SCP_LSB = 3;
   localparam int STX_LSB = 0;
   localparam int NO_CRC_RX_BIT = 7;
   localparam int CRC_TO_FIFO_BIT = 6;
   localparam int MOD_TYPE_BIT = 5;
   localparam int FIELD_DET_BIT = 4;
   localparam int DRIVER_FLOAT_BIT = 3;
   localparam int RX_TOL_BIT = 2;
   localparam int NFC_N_LSB = 0;
   localparam int CH_PICK_BIT = 7;
   localparam int AMD_SEL_BIT = 6;
   localparam int LP_LSB = 3;
   localparam int ZS_HIGH_BIT = 2;
   localparam int ZS_MID_BIT = 1;
   localparam int ZS_LOW_BIT = 0;
   localparam int CTRL_DEFAULT_BIT = 0;
   localparam int CTRL_PRESET_BIT = 1;
   localparam int CTRL_PRESET_AM_BIT = 2;

   // ----------------------------------------------------------------------
   // axi responses
   // ----------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------------
   // decoded divisor and pulse counts
   // ----------------------------------------------------------------------
   localparam logic [7:0] DIV_UNUSED = 8'h00;
   localparam logic [7:0] DIV_SUB_BASE = 8'h40;
   localparam logic [7:0] DIV_BPSK_BASE = 8'h10;
   localparam logic [7:0] DIV_TX_BASE = 8'h80;
   localparam logic [3:0] PULSES_BASE = 4'h1;

   typedef enum logic [0:0] {
      STREAM_SUBCARRIER = 1'b0,
      STREAM_BPSK = 1'b1
   } stream_kind_t;

   typedef struct packed {
      logic [7:0] stream_mode_setup;
      logic [7:0] aux_framing_options;
      logic [7:0] receiver_setup_one;
   } cfg_regs_t;

   typedef struct packed {
      logic [7:0] subcarrier_div;
      logic [3:0] report_pulses;
      logic [7:0] tx_period_div;
      logic stream_cfg_valid;
      logic rx_without_crc;
      logic crc_bytes_to_fifo;
      logic transparent_mod_type;
      logic ext_field_detect_enable;
      logic on_off_driver_float;
      logic decoder_tolerant;
      logic [1:0] field_on_n;
      logic receive_channel_pick;
      logic am_demod_mixer;
      logic [2:0] low_pass_control;
      logic zero_setting_high;
      logic zero_setting_mid;
      logic zero_setting_low;
   } cfg_decoded_t;

endpackage : stream_aux_rx_pkg

// ### verilog/stream_cfg_decode.sv
// decoder that turns the three config bytes into block control signals
`timescale 1ns/1ps
module stream_cfg_decode (
   input wire stream_aux_rx_pkg::cfg_regs_t regs,
   input wire stream_aux_rx_pkg::stream_kind_t stream_kind,
   input wire auto_no_crc,
   output stream_aux_rx_pkg::cfg_decoded_t dec
);

   // ----------------------------------------------------------------------
   // divisor helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] shift_div(input logic [7:0] base, input logic [2:0] code);
      shift_div = base >> code;
   endfunction : shift_div

   logic [1:0] scf;
   logic [1:0] scp;
   logic [2:0] stx;
   logic [7:0] aux;
   logic [7:0] rx1;

   always_comb begin
      scf = regs.stream_mode_setup[stream_aux_rx_pkg::SCF_LSB +: 2];
      scp = regs.stream_mode_setup[stream_aux_rx_pkg::SCP_LSB +: 2];
      stx = regs.stream_mode_setup[stream_aux_rx_pkg::STX_LSB +: 3];
      aux = regs.aux_framing_options;
      rx1 = regs.receiver_setup_one;
      dec = '0;
      if (stream_kind == stream_aux_rx_pkg::STREAM_SUBCARRIER) begin
         dec.subcarrier_div = shift_div(stream_aux_rx_pkg::DIV_SUB_BASE, {1'b0, scf});
      end else if (scf == 2'b11) begin
         dec.subcarrier_div = stream_aux_rx_pkg::DIV_UNUSED;
      end else begin
         dec.subcarrier_div = shift_div(stream_aux_rx_pkg::DIV_BPSK_BASE, {1'b0, scf});
      end
      dec.report_pulses = stream_aux_rx_pkg::PULSES_BASE << scp;
      if (stx == 3'b111) begin
         dec.tx_period_div = stream_aux_rx_pkg::DIV_UNUSED;
      end else begin
         dec.tx_period_div = shift_div(stream_aux_rx_pkg::DIV_TX_BASE, stx);
      end
      // one pulse per period is for bpsk only; unused codes flag invalid
      dec.stream_cfg_valid = (dec.subcarrier_div != stream_aux_rx_pkg::DIV_UNUSED)
         && (dec.tx_period_div != stream_aux_rx_pkg::DIV_UNUSED)
         && !(scp == 2'b00 && stream_kind == stream_aux_rx_pkg::STREAM_SUBCARRIER);
      dec.rx_without_crc = aux[stream_aux_rx_pkg::NO_CRC_RX_BIT] | auto_no_crc;
      dec.crc_bytes_to_fifo = aux[stream_aux_rx_pkg::CRC_TO_FIFO_BIT];
      dec.transparent_mod_type = aux[stream_aux_rx_pkg::MOD_TYPE_BIT];
      dec.ext_field_detect_enable = aux[stream_aux_rx_pkg::FIELD_DET_BIT];
      dec.on_off_driver_float = aux[stream_aux_rx_pkg::DRIVER_FLOAT_BIT];
      dec.decoder_tolerant = aux[stream_aux_rx_pkg::RX_TOL_BIT];
      dec.field_on_n = aux[stream_aux_rx_pkg::NFC_N_LSB +: 2];
      dec.receive_channel_pick = rx1[stream_aux_rx_pkg::CH_PICK_BIT];
      dec.am_demod_mixer = rx1[stream_aux_rx_pkg::AMD_SEL_BIT];
      dec.low_pass_control = rx1[stream_aux_rx_pkg::LP_LSB +: 3];
      dec.zero_setting_high = rx1[stream_aux_rx_pkg::ZS_HIGH_BIT];
      dec.zero_setting_mid = rx1[stream_aux_rx_pkg::ZS_MID_BIT];
      dec.zero_setting_low = rx1[stream_aux_rx_pkg::ZS_LOW_BIT];
   end

endmodule : stream_cfg_decode

// ### verilog/stream_aux_rx_config_regs.sv
// axi4-lite register bank for stream mode, auxiliary framing and receiver setup
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - all three registers return to defaults at reset and on set-default
// - sub-carrier mode frequency code picks fc/64, fc/32, fc/16, fc/8
// - bpsk mode frequency code picks fc/16, fc/8, fc/4; code 11 unused
// - pulse count code gives 1 (bpsk only), 2, 4 or 8 pulses
// - tx period code gives fc/128 halving to fc/2; code 111 unused
// - aux bit 7 makes receiver accept frames without crc
// - reqa, wupa commands and anticollision force receive without crc
// - aux bit 6 keeps crc check but stores crc bytes in fifo
// - modulation type bit: 0 ook, 1 am; preset sets it, writes change it
// - aux bit 4 enables external field detector with peer threshold
// - aux bit 3 floats the rf output driver during ook modulation
// - tolerance bit, default 1, relaxes bpsk fc/32 and first byte handling
// - aux bits 1:0 give n for field-on direct commands
// - receiver bit 7 picks am channel at 0, pm channel at 1
// - receiver bit 6 picks peak detector at 0, mixer at 1
// - receiver bits 5:3 low pass, bits 2:0 zero setting to filters
module stream_aux_rx_config_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [stream_aux_rx_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [stream_aux_rx_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire stream_aux_rx_pkg::stream_kind_t stream_kind,
   input wire logic auto_no_crc,
   output stream_aux_rx_pkg::cfg_decoded_t cfg
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      stream_aux_rx_pkg::cfg_regs_t regs;
      logic aw_held;
      logic [stream_aux_rx_pkg::ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [7:0] w_byte;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      stream_aux_rx_pkg::cfg_decoded_t cfg;
   } state_t;

   state_t s_q;
   state_t s_d;
   stream_aux_rx_pkg::cfg_decoded_t dec;

   function automatic stream_aux_rx_pkg::cfg_regs_t default_regs();
      stream_aux_rx_pkg::cfg_regs_t r;
      r.stream_mode_setup = stream_aux_rx_pkg::STREAM_MODE_SETUP_RST;
      r.aux_framing_options = stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_RST;
      r.receiver_setup_one = stream_aux_rx_pkg::RECEIVER_SETUP_ONE_RST;
      return r;
   endfunction : default_regs

   // ----------------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------------
   stream_cfg_decode u_decode (
      .regs(s_q.regs),
      .stream_kind(stream_kind),
      .auto_no_crc(auto_no_crc),
      .dec(dec)
   );

   assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign cfg = s_q.cfg;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.cfg = dec;
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_held = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_held = 1'b1;
         s_d.w_byte = s_axi_wdata[7:0];
         s_d.w_lane0 = s_axi_wstrb[0];
      end
      if (s_q.aw_held && s_q.w_held) begin
         s_d.aw_held = 1'b0;
         s_d.w_held = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = stream_aux_rx_pkg::RESP_OKAY;
         case (s_q.aw_addr)
            stream_aux_rx_pkg::STREAM_MODE_SETUP_ADDR: begin
               if (s_q.w_lane0) begin
                  s_d.regs.stream_mode_setup = s_q.w_byte & stream_aux_rx_pkg::STREAM_MODE_WMASK;
               end
            end
            stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_ADDR: begin
               if (s_q.w_lane0) begin
                  s_d.regs.aux_framing_options = s_q.w_byte;
               end
            end
            stream_aux_rx_pkg::RECEIVER_SETUP_ONE_ADDR: begin
               if (s_q.w_lane0) begin
                  s_d.regs.receiver_setup_one = s_q.w_byte;
               end
            end
            stream_aux_rx_pkg::CONTROL_ADDR: begin
               if (s_q.w_lane0 && s_q.w_byte[stream_aux_rx_pkg::CTRL_DEFAULT_BIT]) begin
                  s_d.regs = default_regs();
               end else if (s_q.w_lane0 && s_q.w_byte[stream_aux_rx_pkg::CTRL_PRESET_BIT]) begin
                  // analog preset loads the modulation type
                  s_d.regs.aux_framing_options[stream_aux_rx_pkg::MOD_TYPE_BIT] =
                     s_q.w_byte[stream_aux_rx_pkg::CTRL_PRESET_AM_BIT];
               end
            end
            stream_aux_rx_pkg::STATUS_ADDR: begin
               s_d.bresp = stream_aux_rx_pkg::RESP_SLVERR;
            end
            default: begin
               s_d.bresp = stream_aux_rx_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = stream_aux_rx_pkg::RESP_OKAY;
         s_d.rdata = '0;
         case (s_axi_araddr)
            stream_aux_rx_pkg::STREAM_MODE_SETUP_ADDR: begin
               s_d.rdata[7:0] = s_q.regs.stream_mode_setup;
            end
            stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_ADDR: begin
               s_d.rdata[7:0] = s_q.regs.aux_framing_options;
            end
            stream_aux_rx_pkg::RECEIVER_SETUP_ONE_ADDR: begin
               s_d.rdata[7:0] = s_q.regs.receiver_setup_one;
            end
            stream_aux_rx_pkg::CONTROL_ADDR: begin
               s_d.rdata = '0;
            end
            stream_aux_rx_pkg::STATUS_ADDR: begin
               // live view of the block's effective state
               s_d.rdata[0] = dec.stream_cfg_valid;
               s_d.rdata[1] = dec.rx_without_crc;
               s_d.rdata[2] = stream_kind;
            end
            default: begin
               s_d.rresp = stream_aux_rx_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.regs <= default_regs();
      end else begin
         s_q <= s_d;
      end
   end

endmodule : stream_aux_rx_config_regs

// ### test/stream_aux_rx_checker.sv
// checker: port-level assertions for the config bank
`timescale 1ns/1ps
module stream_aux_rx_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire stream_aux_rx_pkg::stream_kind_t stream_kind,
   input wire logic auto_no_crc,
   input wire stream_aux_rx_pkg::cfg_decoded_t cfg
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_answer_s;
      ##2 s_axi_bvalid;
   endsequence
   reset_defaults_a: assert property ($rose(aresetn) |=> cfg.decoder_tolerant
      && cfg.field_on_n == 2'h0 && !cfg.transparent_mod_type) else $error("bad defaults");
   auto_no_crc_a: assert property (auto_no_crc |=> cfg.rx_without_crc)
      else $error("auto no-crc lost");
   sub_div_a: assert property (cfg.stream_cfg_valid && $past(stream_kind) ==
      stream_aux_rx_pkg::STREAM_SUBCARRIER |-> cfg.subcarrier_div inside {8'h40, 8'h20,
      8'h10, 8'h08}) else $error("bad sub-carrier divisor");
   bpsk_div_a: assert property (cfg.stream_cfg_valid && $past(stream_kind) ==
      stream_aux_rx_pkg::STREAM_BPSK |-> cfg.subcarrier_div inside {8'h10, 8'h08, 8'h04})
      else $error("bad bpsk divisor");
   pulse_count_a: assert property (cfg.stream_cfg_valid |->
      cfg.report_pulses inside {4'h1, 4'h2, 4'h4, 4'h8} && ($past(stream_kind) ==
      stream_aux_rx_pkg::STREAM_BPSK || cfg.report_pulses != 4'h1))
      else $error("bad pulse count");
   tx_period_a: assert property (cfg.stream_cfg_valid |-> cfg.tx_period_div inside
      {8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02}) else $error("bad tx period");
   write_answer_a: assert property (wr_taken_s |-> wr_answer_s)
      else $error("write response late");
   read_upper_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000) else $error("bad read answer");
endmodule : stream_aux_rx_checker

// ### test/axi_lite_host.sv
// host model: axi4-lite master issuing register cycles
`timescale 1ns/1ps
module axi_lite_host (
   input wire logic aclk,
   output logic [11:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [11:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   int slow = 0;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // released address and data are scrambled, never left at the last value
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
      output logic [1:0] r);
      logic pa, pw, ta, tw;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ta = pa && awready;
         tw = pw && wready;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (tw) begin
            wvalid <= 1'b0;
            wdata <= ~{24'h000000, d};
         end
         pa = pa && !ta;
         pw = pw && !tw;
      end
      repeat (slow) @(posedge aclk);
      bready <= 1'b1;
      do @(negedge aclk); while (!bvalid);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      araddr <= ~a;
      repeat (slow) @(posedge aclk);
      rready <= 1'b1;
      do @(negedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rd
endmodule : axi_lite_host

// ### test/stream_aux_rx_config_regs_tb.sv
// testbench: register cycles, decode tables, defaults and refusals
`timescale 1ns/1ps
module stream_aux_rx_config_regs_tb;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic [1:0] bresp;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } row_t;
   localparam logic [1:0] OK = stream_aux_rx_pkg::RESP_OKAY;
   localparam logic [1:0] ER = stream_aux_rx_pkg::RESP_SLVERR;
   localparam row_t ROWS [6] = '{
      '{stream_aux_rx_pkg::STREAM_MODE_SETUP_ADDR, 8'hFF, OK, 8'h7F, OK},
      '{stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_ADDR, 8'hA9, OK, 8'hA9, OK},
      '{stream_aux_rx_pkg::RECEIVER_SETUP_ONE_ADDR, 8'h5A, OK, 8'h5A, OK},
      '{12'h040, 8'h11, ER, 8'h00, ER},
      '{stream_aux_rx_pkg::STATUS_ADDR, 8'hFF, ER, 8'h02, OK},
      '{stream_aux_rx_pkg::CONTROL_ADDR, 8'h00, OK, 8'h00, OK}};
   localparam logic [7:0] PATS [2] = '{8'hA9, 8'h56};
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, auto_no_crc;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [7:0] v;
   stream_aux_rx_pkg::stream_kind_t stream_kind;
   stream_aux_rx_pkg::cfg_decoded_t cfg;
   int miscompares = 0;
   int checked = 0;
   stream_aux_rx_config_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stream_kind(stream_kind),
      .auto_no_crc(auto_no_crc), .cfg(cfg));
   axi_lite_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] rr;
      host.rd(a, d, rr);
      if (er === OK) chk(d, {24'h000000, e});
      chk(rr, er);
   endtask : rdchk
   task automatic finish_test();
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      #100000;
      miscompares++;
      finish_test();
   end
   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      aresetn = 1'b0;
      auto_no_crc = 1'b0;
      stream_kind = stream_aux_rx_pkg::STREAM_SUBCARRIER;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ROWS[n]) begin
         host.wr(ROWS[n].addr, ROWS[n].wdata, 4'h1, r);
         chk(r, ROWS[n].bresp);
         rdchk(ROWS[n].addr, ROWS[n].rdata, ROWS[n].rresp);
      end
      for (int i = 0; i < 8; i++) begin
         v = {1'b0, i[1:0], i[1:0], i[2:0]};
         host.wr(stream_aux_rx_pkg::STREAM_MODE_SETUP_ADDR, v, 4'h1, r);
         for (int k = 0; k < 2; k++) begin
            stream_kind <= stream_aux_rx_pkg::stream_kind_t'(k[0]);
            repeat (3) @(negedge aclk);
            chk(cfg.subcarrier_div, k ? (i[1:0] == 2'h3 ? 8'h00 : 8'h10 >> i[1:0]) :
               8'h40 >> i[1:0]);
            chk(cfg.report_pulses, 4'h1 << i[1:0]);
            chk(cfg.tx_period_div, i == 7 ? 8'h00 : 8'h80 >> i);
            chk(cfg.stream_cfg_valid, !(k && i[1:0] == 2'h3) && i != 7
               && !(!k && i[1:0] == 2'h0));
            @(posedge aclk);
         end
      end
      host.slow = 3;
      foreach (PATS[j]) begin
         v = PATS[j];
         host.wr(stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_ADDR, v, 4'h1, r);
         host.wr(stream_aux_rx_pkg::RECEIVER_SETUP_ONE_ADDR, v, 4'h1, r);
         repeat (2) @(negedge aclk);
         chk({cfg.rx_without_crc, cfg.crc_bytes_to_fifo}, v[7:6]);
         chk({cfg.transparent_mod_type, cfg.ext_field_detect_enable}, v[5:4]);
         chk({cfg.on_off_driver_float, cfg.decoder_tolerant}, v[3:2]);
         chk(cfg.field_on_n, v[1:0]);
         chk({cfg.receive_channel_pick, cfg.am_demod_mixer}, v[7:6]);
         chk({cfg.low_pass_control, cfg.zero_setting_high, cfg.zero_setting_mid,
            cfg.zero_setting_low}, v[5:0]);
         @(posedge aclk);
      end
      host.slow = 0;
      auto_no_crc <= 1'b1;
      repeat (2) @(negedge aclk);
      chk(cfg.rx_without_crc, 1'b1);
      @(posedge aclk);
      auto_no_crc <= 1'b0;
      // analog preset forces am, then a masked write must not store
      host.wr(stream_aux_rx_pkg::CONTROL_ADDR, 8'h06, 4'h1, r);
      rdchk(stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_ADDR, 8'h76, OK);
      host.wr(stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_ADDR, 8'h00, 4'h0, r);
      rdchk(stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_ADDR, 8'h76, OK);
      host.wr(stream_aux_rx_pkg::CONTROL_ADDR, 8'h03, 4'h1, r);
      rdchk(stream_aux_rx_pkg::STREAM_MODE_SETUP_ADDR, 8'h00, OK);
      rdchk(stream_aux_rx_pkg::AUX_FRAMING_OPTIONS_ADDR, 8'h04, OK);
      rdchk(stream_aux_rx_pkg::RECEIVER_SETUP_ONE_ADDR, 8'h00, OK);
      host.wr(stream_aux_rx_pkg::RECEIVER_SETUP_ONE_ADDR, 8'hC3, 4'h1, r);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(stream_aux_rx_pkg::RECEIVER_SETUP_ONE_ADDR, 8'h00, OK);
      finish_test();
   end
endmodule : stream_aux_rx_config_regs_tb
bind stream_aux_rx_config_regs stream_aux_rx_checker u_chk (.*);
